// ### hw/ocpc_pkg.sv
// constants shared by the output compare channel block
package ocpc_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int CH_COUNT = 5;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int FAULT_B_CHANNEL = 4;

  // ------------------------------------------------------------
  // register map: address = channel * 4 + register
  // ------------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_PRIMARY = 2'h1;
  localparam logic [1:0] REG_SECONDARY = 2'h2;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_FAULT = 4;
  localparam int BIT_TSEL = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;

  // ------------------------------------------------------------
  // compare modes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_LOW_FIRST = 3'h1;
  localparam logic [2:0] MODE_HIGH_FIRST = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_SINGLE = 3'h4;
  localparam logic [2:0] MODE_CONT = 3'h5;
  localparam logic [2:0] MODE_PWM_FREE = 3'h6;
  localparam logic [2:0] MODE_PWM_FAULT = 3'h7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic FAULT_LEVEL = 1'b0;

endpackage : ocpc_pkg

// ### hw/ocpc_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module ocpc_sync #(
  parameter int W = 2
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } ocpc_sync_state_t;

  ocpc_sync_state_t st;
  ocpc_sync_state_t next_st;

  // ------------------------------------------------------------
  // stage1 is read only by stage2
  // ------------------------------------------------------------
  always_comb begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // start at the idle level so no fault shows right after reset
      st.stage1 <= {W{!ocpc_pkg::FAULT_LEVEL}};
      st.stage2 <= {W{!ocpc_pkg::FAULT_LEVEL}};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;

endmodule : ocpc_sync

`default_nettype wire

// ### hw/ocpc_top.sv
// five output compare / pwm channels with their register port
//
// Behaviour
// - mode 000 disables the channel; pin stays low, no compare activity.
// - mode 001 drives low, then high on primary match.
// - mode 010 drives high, then low on compare match.
// - mode 011 toggles the pin on every compare match.
// - mode 100 starts low, makes exactly one pulse, then stays low.
// - mode 101 starts low, makes one pulse every timer period, forever.
// - mode 110 is pwm with the fault pin ignored.
// - mode 111 is pwm with the fault pin monitored.
// - fault status bit 4 set by pwm fault in 111; software cannot write it.
// - time-base bit 3 selects second timer when 1, first timer when 0.
// - idle-stop bit 13 set halts the channel while the cpu idles.
// - first fault pin serves channels one to four, second serves channel five.
// - five independent channels, each with control, primary and secondary registers.
// - control bits 15..14 and 12..5 read zero and ignore writes.
// - pwm copies secondary into read-only duty only at timer period match.
// - pulse modes rise at primary match and fall at secondary match.
// - pulse modes set the channel interrupt flag on each pulse-ending match.
// - pwm duty zero holds low; duty above period holds high.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ocpc_top #(
  parameter int CH = ocpc_pkg::CH_COUNT
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ocpc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] timer_count_reg_a,
  input wire logic [15:0] timer_period_reg_a,
  input wire logic timer_tick_a,
  input wire logic [15:0] timer_count_reg_b,
  input wire logic [15:0] timer_period_reg_b,
  input wire logic timer_tick_b,
  input wire logic cpu_idle,
  input wire logic fault_input_a,
  input wire logic fault_input_b,
  output logic [CH-1:0] compare_output_pin,
  output logic [CH-1:0] channel_irq_flag
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CH-1:0][2:0] mode;
    logic [CH-1:0] tsel;
    logic [CH-1:0] idle_stop;
    logic [CH-1:0] fault;
    logic [CH-1:0][15:0] primary;
    logic [CH-1:0][15:0] secondary;
    logic [CH-1:0] out;
    logic [CH-1:0] done;
    logic [CH-1:0] irq;
    logic [15:0] rdata;
  } ocpc_state_t;

  ocpc_state_t st;
  ocpc_state_t next_st;

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == ocpc_pkg::MODE_PWM_FREE) || (m == ocpc_pkg::MODE_PWM_FAULT);
  endfunction : is_pwm

  function automatic logic sel_reg(input logic [ocpc_pkg::ADDR_W-1:0] a, input int ch,
                                   input logic [1:0] r);
    sel_reg = (a[ocpc_pkg::ADDR_W-1:2] == 3'(ch)) && (a[1:0] == r);
  endfunction : sel_reg

  // ------------------------------------------------------------
  // fault pins come from outside: synchronise first
  // ------------------------------------------------------------
  logic [1:0] fault_sync;

  ocpc_sync #(
    .W(2)
  ) u_fault_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({fault_input_b, fault_input_a}),
    .sync_out(fault_sync)
  );

  // ------------------------------------------------------------
  // per-channel compare events
  // ------------------------------------------------------------
  logic [CH-1:0][15:0] cnt;
  logic [CH-1:0] tick;
  logic [CH-1:0] hit_pri;
  logic [CH-1:0] hit_sec;
  logic [CH-1:0] hit_per;
  logic [CH-1:0] hit_zero;
  logic [CH-1:0] run;
  logic [CH-1:0] ctrl_wr;
  logic [CH-1:0] fault_act;

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      cnt[i] = st.tsel[i] ? timer_count_reg_b : timer_count_reg_a;
      tick[i] = st.tsel[i] ? timer_tick_b : timer_tick_a;
      hit_per[i] = tick[i] &&
        (cnt[i] == (st.tsel[i] ? timer_period_reg_b : timer_period_reg_a));
      hit_pri[i] = tick[i] && (cnt[i] == st.primary[i]);
      hit_sec[i] = tick[i] && (cnt[i] == st.secondary[i]);
      hit_zero[i] = tick[i] && (cnt[i] == 16'h0000);
      run[i] = !(st.idle_stop[i] && cpu_idle);
      ctrl_wr[i] = reg_wr && sel_reg(reg_addr, i, ocpc_pkg::REG_CTRL);
      fault_act[i] = ((i == ocpc_pkg::FAULT_B_CHANNEL) ? fault_sync[1] : fault_sync[0])
                     == ocpc_pkg::FAULT_LEVEL;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [2:0] wmode;
    wmode = reg_wdata[ocpc_pkg::MODE_LSB +: ocpc_pkg::MODE_W];
    next_st = st;
    next_st.irq = '0;
    next_st.rdata = 16'h0000;
    for (int i = 0; i < CH; i++) begin
      // register reads; unmapped addresses read zero
      if (reg_rd && sel_reg(reg_addr, i, ocpc_pkg::REG_CTRL)) begin
        next_st.rdata[ocpc_pkg::BIT_IDLE_STOP] = st.idle_stop[i];
        next_st.rdata[ocpc_pkg::BIT_FAULT] = st.fault[i];
        next_st.rdata[ocpc_pkg::BIT_TSEL] = st.tsel[i];
        next_st.rdata[ocpc_pkg::MODE_LSB +: ocpc_pkg::MODE_W] = st.mode[i];
      end
      if (reg_rd && sel_reg(reg_addr, i, ocpc_pkg::REG_PRIMARY)) begin
        next_st.rdata = st.primary[i];
      end
      if (reg_rd && sel_reg(reg_addr, i, ocpc_pkg::REG_SECONDARY)) begin
        next_st.rdata = st.secondary[i];
      end
      // compare registers; primary is read-only duty in pwm
      if (reg_wr && sel_reg(reg_addr, i, ocpc_pkg::REG_PRIMARY) && !is_pwm(st.mode[i])) begin
        next_st.primary[i] = reg_wdata;
      end
      if (reg_wr && sel_reg(reg_addr, i, ocpc_pkg::REG_SECONDARY)) begin
        next_st.secondary[i] = reg_wdata;
      end
      if (ctrl_wr[i]) begin
        // a mode write re-arms the channel and sets the initial pin level; toggle mode keeps the current level
        next_st.mode[i] = wmode;
        next_st.tsel[i] = reg_wdata[ocpc_pkg::BIT_TSEL];
        next_st.idle_stop[i] = reg_wdata[ocpc_pkg::BIT_IDLE_STOP];
        next_st.done[i] = 1'b0;
        // fault bit ignores the written value; a fault in this cycle still wins
        next_st.fault[i] = (wmode == ocpc_pkg::MODE_PWM_FAULT) && fault_act[i];
        case (wmode)
          ocpc_pkg::MODE_HIGH_FIRST: next_st.out[i] = 1'b1;
          ocpc_pkg::MODE_TOGGLE: next_st.out[i] = st.out[i];
          default: next_st.out[i] = 1'b0;
        endcase
      end else if (run[i]) begin
        case (st.mode[i])
          ocpc_pkg::MODE_OFF: begin
            next_st.out[i] = 1'b0;
          end
          ocpc_pkg::MODE_LOW_FIRST: begin
            if (hit_pri[i]) begin
              next_st.out[i] = 1'b1;
              next_st.irq[i] = 1'b1;
            end
          end
          ocpc_pkg::MODE_HIGH_FIRST: begin
            if (hit_pri[i]) begin
              next_st.out[i] = 1'b0;
              next_st.irq[i] = 1'b1;
            end
          end
          ocpc_pkg::MODE_TOGGLE: begin
            if (hit_pri[i]) begin
              next_st.out[i] = !st.out[i];
              next_st.irq[i] = 1'b1;
            end
          end
          ocpc_pkg::MODE_SINGLE, ocpc_pkg::MODE_CONT: begin
            // equal primary and secondary: the fall wins, pin stays low
            // a secondary match with the pin still low ends no pulse, so
            // arming inside the window cannot swallow the single pulse
            if (!st.done[i]) begin
              if (hit_sec[i]) begin
                if (st.out[i]) begin
                  next_st.out[i] = 1'b0;
                  next_st.irq[i] = 1'b1;
                  next_st.done[i] = (st.mode[i] == ocpc_pkg::MODE_SINGLE);
                end
              end else if (hit_pri[i]) begin
                next_st.out[i] = 1'b1;
              end
            end
          end
          default: begin
            if ((st.mode[i] == ocpc_pkg::MODE_PWM_FAULT) &&
                (fault_act[i] || st.fault[i])) begin
              // latched until the mode field is rewritten
              next_st.fault[i] = 1'b1;
              next_st.irq[i] = !st.fault[i];
              next_st.out[i] = 1'b0;
            end else begin
              if (hit_per[i]) begin
                next_st.primary[i] = st.secondary[i];
              end
              if (hit_zero[i]) begin
                next_st.out[i] = (st.primary[i] != 16'h0000);
              end else if (hit_pri[i]) begin
                next_st.out[i] = 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      for (int i = 0; i < CH; i++) begin
        st.mode[i] <= ocpc_pkg::CTRL_RESET[2:0];
        st.primary[i] <= ocpc_pkg::CMP_RESET;
        st.secondary[i] <= ocpc_pkg::CMP_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  assign compare_output_pin = st.out;
  assign channel_irq_flag = st.irq;
  assign reg_rdata = st.rdata;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  for (genvar g = 0; g < CH; g++) begin : g_chk
    logic quiet;
    logic pwm_ok;
    assign quiet = run[g] && !ctrl_wr[g];
    // a fault in this cycle takes the pwm branch away
    assign pwm_ok = is_pwm(st.mode[g]) && quiet && !st.fault[g] &&
      !((st.mode[g] == ocpc_pkg::MODE_PWM_FAULT) && fault_act[g]);

    sequence s_pulse_mode;
      (st.mode[g] == ocpc_pkg::MODE_SINGLE) || (st.mode[g] == ocpc_pkg::MODE_CONT);
    endsequence
    sequence s_pulse_end;
      s_pulse_mode ##0 (quiet && hit_sec[g] && !st.done[g] && st.out[g]);
    endsequence
    sequence s_pulse_start;
      s_pulse_mode ##0 (quiet && hit_pri[g] && !hit_sec[g] && !st.done[g]);
    endsequence

    a_off_pin_low: assert property (
      (st.mode[g] == ocpc_pkg::MODE_OFF) |-> !compare_output_pin[g] && !channel_irq_flag[g])
      else $error("disabled channel drives pin or flag");
    a_rise_on_match: assert property (
      (st.mode[g] == ocpc_pkg::MODE_LOW_FIRST) && quiet && hit_pri[g]
      |=> compare_output_pin[g] && channel_irq_flag[g])
      else $error("pin not driven high on match");
    a_fall_on_match: assert property (
      (st.mode[g] == ocpc_pkg::MODE_HIGH_FIRST) && quiet && hit_pri[g]
      |=> !compare_output_pin[g])
      else $error("pin not forced low on match");
    a_toggle_match: assert property (
      (st.mode[g] == ocpc_pkg::MODE_TOGGLE) && quiet && hit_pri[g]
      |=> compare_output_pin[g] != $past(compare_output_pin[g]))
      else $error("pin did not toggle");
    a_single_once: assert property (
      (st.mode[g] == ocpc_pkg::MODE_SINGLE) && st.done[g] |-> !compare_output_pin[g])
      else $error("single pulse repeated");
    a_pulse_rise: assert property (
      s_pulse_start |=> compare_output_pin[g])
      else $error("pulse did not rise");
    a_pulse_end_flag: assert property (
      s_pulse_end |=> !compare_output_pin[g] && channel_irq_flag[g])
      else $error("pulse end without fall or flag");
    a_pwm_free_ok: assert property (
      (st.mode[g] == ocpc_pkg::MODE_PWM_FREE) |-> !st.fault[g])
      else $error("fault seen in fault-free pwm");
    a_fault_stops: assert property (
      (st.mode[g] == ocpc_pkg::MODE_PWM_FAULT) && quiet && fault_act[g] && !st.fault[g]
      |=> st.fault[g] && !compare_output_pin[g] && channel_irq_flag[g]
      ##1 (st.fault[g] || $past(ctrl_wr[g])))
      else $error("fault did not stop pwm");
    a_duty_latch: assert property (
      pwm_ok && hit_per[g] && !hit_zero[g]
      |=> st.primary[g] == $past(st.secondary[g]))
      else $error("duty not latched at period match");
    a_pwm_wrap: assert property (
      pwm_ok && hit_zero[g]
      |=> compare_output_pin[g] == ($past(st.primary[g]) != 16'h0000))
      else $error("pwm wrap level wrong");
    a_idle_hold: assert property (
      st.idle_stop[g] && cpu_idle && !ctrl_wr[g] |=> $stable(compare_output_pin[g]))
      else $error("channel ran while idle-stopped");

    // ------------------------------------------------------------
    // duty, pulse, fault and idle checks
    // ------------------------------------------------------------
    a_pwm_duty_fall: assert property (
      pwm_ok && hit_pri[g] && !hit_zero[g]
      |=> !compare_output_pin[g])
      else $error("pwm did not fall at duty match");
    a_duty_read_only: assert property (
      is_pwm(st.mode[g]) && !ctrl_wr[g] && !hit_per[g]
      |=> $stable(st.primary[g]))
      else $error("duty changed outside period match");
    a_single_done: assert property (
      s_pulse_end ##0 (st.mode[g] == ocpc_pkg::MODE_SINGLE)
      |=> st.done[g])
      else $error("single pulse not closed");
    a_cont_rearm: assert property (
      (st.mode[g] == ocpc_pkg::MODE_CONT) |-> !st.done[g])
      else $error("continuous pulses stopped");
    a_fault_mode_only: assert property (
      st.fault[g] |-> (st.mode[g] == ocpc_pkg::MODE_PWM_FAULT))
      else $error("fault bit set outside fault-checked pwm");
    a_fault_held: assert property (
      st.fault[g] && !ctrl_wr[g] |=> st.fault[g])
      else $error("fault bit cleared without mode rewrite");
    a_fault_pin_low: assert property (
      st.fault[g] |-> !compare_output_pin[g])
      else $error("faulted channel drives pin high");
    a_idle_no_flag: assert property (
      st.idle_stop[g] && cpu_idle && !ctrl_wr[g] |=> !channel_irq_flag[g])
      else $error("idle-stopped channel raised flag");
  end

  a_unimpl_zero: assert property (
    reg_rd && (reg_addr[1:0] == ocpc_pkg::REG_CTRL)
    |=> (reg_rdata[15:14] == 2'h0) && (reg_rdata[12:5] == 8'h00))
    else $error("unimplemented control bits read nonzero");

endmodule : ocpc_top

`default_nettype wire

// ### sim/ocpc_far_side.sv
// far-side model: two free-running time bases and the two fault pins
`timescale 1ns/1ps
`default_nettype none

module ocpc_far_side (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [15:0] period_a,
  input wire logic [15:0] period_b,
  input wire logic fault_on_a,
  input wire logic fault_on_b,
  output logic [15:0] count_a,
  output logic [15:0] count_b,
  output logic tick_a,
  output logic tick_b,
  output logic fault_pin_a,
  output logic fault_pin_b
);
  // pins idle high through pull-ups; a fault pulls them low
  assign fault_pin_a = !fault_on_a;
  assign fault_pin_b = !fault_on_b;

  // ------------------------------------------------------------
  // time bases
  // ------------------------------------------------------------
  // wrap after the period match; one tick marks each new count value
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_a <= 16'h0000;
      count_b <= 16'h0000;
      tick_a <= 1'b0;
      tick_b <= 1'b0;
    end else begin
      count_a <= (count_a == period_a) ? 16'h0000 : count_a + 16'h0001;
      count_b <= (count_b == period_b) ? 16'h0000 : count_b + 16'h0001;
      tick_a <= 1'b1;
      tick_b <= 1'b1;
    end
  end
endmodule : ocpc_far_side
`default_nettype wire

// ### sim/tb_output_compare_pwm_channel.sv
// self-checking bench for the five-channel output compare block
`timescale 1ns/1ps
`default_nettype none

module tb_output_compare_pwm_channel;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] cnt_a, cnt_b;
  logic [15:0] per_a = 16'h0014;
  logic [15:0] per_b = 16'h001e;
  logic tk_a, tk_b, fpin_a, fpin_b;
  logic cpu_idle = 1'b0;
  logic flt_a_on = 1'b0;
  logic flt_b_on = 1'b0;
  logic [4:0] pin, irq;
  int fail_count = 0;
  int n_compared = 0;

  always #2.5 sys_clk = ~sys_clk;

  ocpc_top u_ocpc_top (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_count_reg_a(cnt_a), .timer_period_reg_a(per_a), .timer_tick_a(tk_a),
    .timer_count_reg_b(cnt_b), .timer_period_reg_b(per_b), .timer_tick_b(tk_b),
    .cpu_idle(cpu_idle), .fault_input_a(fpin_a), .fault_input_b(fpin_b),
    .compare_output_pin(pin), .channel_irq_flag(irq));

  ocpc_far_side u_ocpc_far_side (.sys_clk(sys_clk), .srst(srst), .period_a(per_a),
    .period_b(per_b), .fault_on_a(flt_a_on), .fault_on_b(flt_b_on), .count_a(cnt_a),
    .count_b(cnt_b), .tick_a(tk_a), .tick_b(tk_b), .fault_pin_a(fpin_a),
    .fault_pin_b(fpin_b));

  // ------------------------------------------------------------
  // closing, compares, bus and wait helpers
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic wr(input logic [2:0] ch, input logic [1:0] r, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= {ch, r};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] ch, input logic [1:0] r, input logic [15:0] exp,
                        input string what);
    @(posedge sys_clk);
    reg_addr <= {ch, r};
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk16(what, exp, reg_rdata);
  endtask : rd_chk

  // sel picks the irq line instead of the pin
  task automatic wait_pin(input logic [2:0] ch, input logic v, input int lim, input logic sel);
    for (int i = 0; i < lim; i++) begin
      if ((sel ? irq[ch] : pin[ch]) === v) return;
      @(posedge sys_clk);
      #1;
    end
    fail_count++;
    $display("MISMATCH wait on channel %0d expected %b seen %b", ch, v,
             sel ? irq[ch] : pin[ch]);
    finish_test();
  endtask : wait_pin

  task automatic wait_cnt(input logic [15:0] v);
    for (int i = 0; i < 64; i++) begin
      if (cnt_a === v) return;
      @(posedge sys_clk);
      #1;
    end
    fail_count++;
    $display("MISMATCH timer wait expected %h seen %h", v, cnt_a);
    finish_test();
  endtask : wait_cnt

  task automatic hold(input logic [2:0] ch, input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      ok &= (pin[ch] === v);
    end
    chk1("pin held", 1'b1, ok);
  endtask : hold

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd_chk(0, ocpc_pkg::REG_CTRL, 16'h0000, "ctrl reset");
    wr(0, ocpc_pkg::REG_CTRL, 16'hfff8);
    rd_chk(0, ocpc_pkg::REG_CTRL, 16'h2008, "ctrl mask");
    wr(0, 2'h3, 16'h1234);
    rd_chk(0, 2'h3, 16'h0000, "unmapped");
    for (logic [2:0] c = 0; c < 5; c++) wr(c, ocpc_pkg::REG_PRIMARY, {13'h0020, c});
    for (logic [2:0] c = 0; c < 5; c++) begin
      rd_chk(c, ocpc_pkg::REG_PRIMARY, {13'h0020, c}, "primary");
    end
  endtask : t_regs

  task automatic t_edge(input logic [2:0] ch, input logic [2:0] m, input logic ts,
                        input logic [15:0] p);
    logic lvl;
    lvl = (m == ocpc_pkg::MODE_HIGH_FIRST);
    wr(ch, ocpc_pkg::REG_PRIMARY, p);
    wr(ch, ocpc_pkg::REG_CTRL, {12'h000, ts, m});
    chk1("start level", lvl, pin[ch]);
    wait_pin(ch, !lvl, 80, 1'b0);
    chk16("match count", p + 16'h0001, ts ? cnt_b : cnt_a);
    hold(ch, !lvl, 40);
  endtask : t_edge

  task automatic t_pulse(input logic [2:0] ch, input logic [2:0] m);
    wr(ch, ocpc_pkg::REG_PRIMARY, 16'h0004);
    wr(ch, ocpc_pkg::REG_SECONDARY, 16'h0009);
    wr(ch, ocpc_pkg::REG_CTRL, {13'h0000, m});
    chk1("pulse start", 1'b0, pin[ch]);
    wait_pin(ch, 1'b1, 40, 1'b0);
    chk16("pulse rise", 16'h0005, cnt_a);
    wait_pin(ch, 1'b0, 40, 1'b0);
    chk16("pulse fall", 16'h000a, cnt_a);
    chk1("pulse irq", 1'b1, irq[ch]);
    if (m == ocpc_pkg::MODE_SINGLE) begin
      hold(ch, 1'b0, 50);
    end else begin
      wait_pin(ch, 1'b1, 40, 1'b0);
      chk16("next rise", 16'h0005, cnt_a);
    end
  endtask : t_pulse

  // fault pin active throughout: mode 110 must not notice it
  task automatic t_pwm();
    wr(0, ocpc_pkg::REG_CTRL, 16'h0000);
    wr(0, ocpc_pkg::REG_PRIMARY, 16'h0008);
    wr(0, ocpc_pkg::REG_SECONDARY, 16'h0008);
    flt_a_on <= 1'b1;
    wr(0, ocpc_pkg::REG_CTRL, 16'h0006);
    wait_pin(0, 1'b1, 40, 1'b0);
    chk16("pwm rise", 16'h0001, cnt_a);
    wait_pin(0, 1'b0, 40, 1'b0);
    chk16("pwm fall", 16'h0009, cnt_a);
    wait_cnt(16'h0002);
    wr(0, ocpc_pkg::REG_SECONDARY, 16'h0000);
    rd_chk(0, ocpc_pkg::REG_PRIMARY, 16'h0008, "duty kept");
    wait_cnt(16'h0001);
    rd_chk(0, ocpc_pkg::REG_PRIMARY, 16'h0000, "duty loaded");
    hold(0, 1'b0, 42);
    wr(0, ocpc_pkg::REG_SECONDARY, 16'h001e);
    wait_cnt(16'h0000);
    wait_cnt(16'h0002);
    hold(0, 1'b1, 42);
    flt_a_on <= 1'b0;
  endtask : t_pwm

  task automatic t_fault();
    wr(4, ocpc_pkg::REG_CTRL, 16'h0000);
    wr(4, ocpc_pkg::REG_PRIMARY, 16'h0008);
    wr(4, ocpc_pkg::REG_SECONDARY, 16'h0008);
    flt_a_on <= 1'b1;
    wr(4, ocpc_pkg::REG_CTRL, 16'h0007);
    wr(3, ocpc_pkg::REG_CTRL, 16'h0007);
    wait_pin(4, 1'b1, 40, 1'b0);
    wait_pin(4, 1'b0, 40, 1'b0);
    rd_chk(4, ocpc_pkg::REG_CTRL, 16'h0007, "other fault pin");
    rd_chk(3, ocpc_pkg::REG_CTRL, 16'h0017, "first fault pin");
    flt_a_on <= 1'b0;
    flt_b_on <= 1'b1;
    wait_pin(4, 1'b1, 10, 1'b1);
    chk1("fault pin low", 1'b0, pin[4]);
    rd_chk(4, ocpc_pkg::REG_CTRL, 16'h0017, "fault bit");
    flt_b_on <= 1'b0;
    hold(4, 1'b0, 45);
    wr(4, ocpc_pkg::REG_CTRL, 16'h0007);
    rd_chk(4, ocpc_pkg::REG_CTRL, 16'h0007, "fault cleared");
    wait_pin(4, 1'b1, 40, 1'b0);
  endtask : t_fault

  task automatic t_idle();
    logic lvl;
    wr(2, ocpc_pkg::REG_CTRL, 16'h2003);
    wr(1, ocpc_pkg::REG_PRIMARY, 16'h0003);
    wr(1, ocpc_pkg::REG_CTRL, 16'h0003);
    lvl = pin[2];
    cpu_idle <= 1'b1;
    wait_pin(1, !pin[1], 40, 1'b0);
    hold(2, lvl, 42);
    cpu_idle <= 1'b0;
    wait_pin(2, !lvl, 40, 1'b0);
  endtask : t_idle

  task automatic t_off();
    logic ok;
    ok = 1'b1;
    for (logic [2:0] c = 0; c < 5; c++) wr(c, ocpc_pkg::REG_CTRL, 16'h0000);
    repeat (42) begin
      @(posedge sys_clk);
      #1;
      ok &= (pin === 5'h00) && (irq === 5'h00);
    end
    chk1("all quiet", 1'b1, ok);
  endtask : t_off

  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_edge(0, ocpc_pkg::MODE_LOW_FIRST, 1'b0, 16'h0005);
    t_edge(1, ocpc_pkg::MODE_HIGH_FIRST, 1'b1, 16'h0019);
    wr(2, ocpc_pkg::REG_PRIMARY, 16'h0003);
    wr(2, ocpc_pkg::REG_CTRL, 16'h0003);
    wait_pin(2, 1'b1, 40, 1'b0);
    chk16("toggle up", 16'h0004, cnt_a);
    wait_pin(2, 1'b0, 40, 1'b0);
    chk16("toggle down", 16'h0004, cnt_a);
    t_pulse(3, ocpc_pkg::MODE_SINGLE);
    t_pulse(4, ocpc_pkg::MODE_CONT);
    t_pwm();
    t_fault();
    t_idle();
    t_off();
    finish_test();
  end
endmodule : tb_output_compare_pwm_channel
`default_nettype wire
